// File: rtl/pmpw_pkg.sv
// Shared constants, types and decode functions for the command register logic
package pmpw_pkg;
   localparam logic [7:0] CMD_PAGE = 8'h00;
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_ONOFF_CFG = 8'h02;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
   localparam logic [7:0] CMD_STORE_ALL = 8'h15;
   localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
   localparam logic [7:0] CMD_STATUS = 8'h78;
   localparam int PAGE_ALL_BIT = 7;
   localparam int PAGE_IDX_BIT = 0;
   localparam int OP_ON_BIT = 7;
   localparam int OP_MRG_HI = 5;
   localparam int OP_MRG_LO = 2;
   localparam int CFG_PU_BIT = 4;
   localparam int CFG_CMD_BIT = 3;
   localparam int CFG_CPR_BIT = 2;
   localparam int CFG_POL_BIT = 1;
   localparam int WP_B5 = 5;
   localparam int WP_B6 = 6;
   localparam int WP_B7 = 7;
   localparam int ST_OFF_BIT = 6;
   localparam int ST_CML_BIT = 1;
   localparam int ST_FAULT_BIT = 0;
   localparam logic [7:0] PAGE_WR_MASK = 8'h81;
   localparam logic [7:0] OP_WR_MASK = 8'hBC;
   localparam logic [7:0] CFG_WR_MASK = 8'h1E;
   localparam logic [7:0] WP_WR_MASK = 8'hE0;
   localparam logic [7:0] CFG_RESET = 8'h16;
   localparam logic [7:0] OP_RESET = 8'h00;
   localparam logic [7:0] WP_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [3:0] MRG_LOW_IGN = 4'h5;
   localparam logic [3:0] MRG_LOW_ACT = 4'h6;
   localparam logic [3:0] MRG_HIGH_IGN = 4'h9;
   localparam logic [3:0] MRG_HIGH_ACT = 4'hA;
   localparam logic [1:0] MRG_OFF_TOP = 2'h0;
   localparam logic [1:0] NVM_LAST = 2'h2;
   localparam logic [1:0] CNT_ONE = 2'h1;
   localparam logic [1:0] CNT_ZERO = 2'h0;

   typedef enum logic [1:0] {MRG_OFF = 2'b00, MRG_LOW = 2'b01, MRG_HIGH = 2'b10} pmpw_margin_e;
   typedef enum logic [1:0] {ST_LOAD = 2'b00, ST_IDLE = 2'b01, ST_SAVE = 2'b10} pmpw_state_e;
   typedef struct packed {logic valid; logic write; logic [7:0] code; logic [7:0] wdata;} pmpw_req_s;
   typedef struct packed {logic valid; logic ack; logic [7:0] rdata;} pmpw_rsp_s;
   typedef struct packed {
      logic on; logic pu; logic cmd; logic cpr; logic pol; pmpw_margin_e margin; logic act;
   } pmpw_chan_ctl_s;

   function automatic logic margin_known(logic [3:0] m);
      return (m[3:2] == MRG_OFF_TOP) || (m == MRG_LOW_IGN) || (m == MRG_LOW_ACT) ||
             (m == MRG_HIGH_IGN) || (m == MRG_HIGH_ACT);
   endfunction : margin_known

   function automatic pmpw_margin_e margin_decode(logic [3:0] m);
      if (m == MRG_LOW_IGN || m == MRG_LOW_ACT) return MRG_LOW;
      if (m == MRG_HIGH_IGN || m == MRG_HIGH_ACT) return MRG_HIGH;
      return MRG_OFF;
   endfunction : margin_decode

   function automatic logic wp_legal(logic [7:0] w);
      return !((w[WP_B5] & w[WP_B6]) | (w[WP_B5] & w[WP_B7]) | (w[WP_B6] & w[WP_B7]));
   endfunction : wp_legal

   function automatic logic wp_allows(logic [7:0] w, logic [7:0] code);
      if (code == CMD_WRITE_LOCK) return 1'b1;
      if (w[WP_B7]) return 1'b0;
      if (w[WP_B6]) return (code == CMD_PAGE) || (code == CMD_OPERATION);
      if (w[WP_B5]) return (code == CMD_PAGE) || (code == CMD_OPERATION) || (code == CMD_ONOFF_CFG);
      return 1'b1;
   endfunction : wp_allows
endpackage : pmpw_pkg

// File: rtl/pmpw_nvm.sv
// Non-volatile store of the start-up configuration and write lock bytes
`timescale 1ns/1ps
module pmpw_nvm (
   // Clock
   input wire logic clk_sys,
   // Write port
   input wire logic we,
   input wire logic [1:0] waddr,
   input wire logic [7:0] wdata,
   // Read port
   input wire logic [1:0] raddr,
   output logic [7:0] rdata
);
   import pmpw_pkg::*;

   typedef struct packed {logic [3:0][7:0] mem; logic [7:0] rdata;} pmpw_nvm_s;

   // Contents survive reset on purpose; they model the stored defaults
   pmpw_nvm_s st_reg = '{mem: {BYTE_ZERO, WP_RESET, CFG_RESET, CFG_RESET}, rdata: BYTE_ZERO};
   pmpw_nvm_s st_next;

   always_comb begin
      st_next = st_reg;
      if (we) begin
         st_next.mem[waddr] = wdata;
      end
      st_next.rdata = st_reg.mem[raddr];
   end

   always_ff @(posedge clk_sys) begin
      st_reg <= st_next;
   end

   assign rdata = st_reg.rdata;
endmodule : pmpw_nvm

// File: rtl/pmpw_chan.sv
// Per-channel on/off decision, fault latch-off and margin selection
`timescale 1ns/1ps
module pmpw_chan (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control
   input wire pmpw_pkg::pmpw_chan_ctl_s ctl,
   input wire logic boot_done,
   input wire logic pin,
   input wire logic fault,
   input wire logic power_ok,
   // Power stage
   output logic gate_en,
   output pmpw_pkg::pmpw_margin_e margin,
   output logic act_on_fault
);
   import pmpw_pkg::*;

   typedef struct packed {logic latched; logic gate_en; pmpw_margin_e margin; logic act;} pmpw_chan_s;

   pmpw_chan_s st_reg;
   pmpw_chan_s st_next;
   logic pin_on;
   logic run;

   always_comb begin
      st_next = st_reg;
      pin_on = ctl.pol ? pin : ~pin;
      run = ~ctl.pu | ((~ctl.cmd | ctl.on) & (~ctl.cpr | pin_on));
      if (!run) begin
         st_next.latched = 1'b0;
      end else if (fault && ctl.act && st_reg.gate_en) begin
         st_next.latched = 1'b1;
      end
      // Pin release drops run; the ramp-down delay belongs to the sequencer
      st_next.gate_en = boot_done & power_ok & run & ~st_next.latched & ~(fault & ctl.act);
      st_next.margin = ctl.margin;
      st_next.act = ctl.act;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_reg <= '{latched: 1'b0, gate_en: 1'b0, margin: MRG_OFF, act: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign gate_en = st_reg.gate_en;
   assign margin = st_reg.margin;
   assign act_on_fault = st_reg.act;
endmodule : pmpw_chan

// File: rtl/pmpw_top.sv
// Command register logic: page, operation, start-up policy, fault clear, write lock
// Notes on behaviour
// - Page bit 7 all-channels, bit 0 index; value 10 ignored entirely.
// - With both channels selected, reads return first channel data.
// - Writes to read-only registers or bits are dropped silently.
// - Operation on bit 0 holds drivers off; 1 allows start without fault.
// - Margin field decodes off, low or high; low and high each ignore or act on faults, off always acts.
// - A channel keeps its mode until a new command or pin change.
// - Start-up config bits 4..0 with defaults 1,0,1,1,0; bits 7..5 unused.
// - Policy bit 0 starts with power; 1 waits for pin and command.
// - Command-response bit decides whether the operation on bit is obeyed.
// - Pin-response bit decides whether the control pin must be asserted.
// - Pin polarity changes only after store and a power cycle.
// - Pin-action bit fixed 0: pin release turns off with programmed delay; here gate_enable drops on the next clock.
// - Clear faults wipes selected page status; the alert releases once no fault or communication bit of either channel is set.
// - Clearing faults never restarts a latched-off channel.
// - A persisting fault sets its bit again at once and alerts.
// - Page, operation, config, lock and status stay readable under any write lock.
// - Lock bit 5 allows only lock, page, operation and config writes.
// - Lock bit 6 allows only lock, page and operation writes.
// - Lock bit 7 allows only writes to the lock register.
// - Several lock bits at once is invalid: alert and communication fault.
// - Config and lock bytes can be stored as power-up defaults.
// - Clear faults carries no data and acts on the code alone.
`timescale 1ns/1ps
module pmpw_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Command port
   input wire pmpw_pkg::pmpw_req_s cmd_req,
   output pmpw_pkg::pmpw_rsp_s cmd_rsp,
   // Channel inputs
   input wire logic [1:0] channel_control_pin,
   input wire logic [1:0] fault_present,
   input wire logic power_ok,
   // Power stage
   output logic [1:0] gate_enable,
   output pmpw_pkg::pmpw_margin_e [1:0] margin_mode,
   output logic [1:0] margin_act_on_fault,
   // Alert
   output logic smbalert_n
);
   import pmpw_pkg::*;

   typedef struct packed {
      pmpw_state_e fsm;
      logic [1:0] cnt;
      logic restore;
      logic page_all;
      logic page_idx;
      logic [1:0][7:0] op;
      logic [1:0][7:0] cfg;
      logic [7:0] wp;
      logic [1:0] pol_active;
      logic [1:0] fault_st;
      logic [1:0] cml_st;
      pmpw_rsp_s rsp;
      logic alert_n;
   } pmpw_top_s;

   localparam pmpw_top_s TOP_RESET = '{
      fsm: ST_LOAD,
      cnt: CNT_ZERO,
      restore: 1'b0,
      page_all: 1'b0,
      page_idx: 1'b0,
      op: {OP_RESET, OP_RESET},
      cfg: {CFG_RESET, CFG_RESET},
      wp: WP_RESET,
      pol_active: 2'b11,
      fault_st: 2'b00,
      cml_st: 2'b00,
      rsp: '0,
      alert_n: 1'b1
   };

   pmpw_top_s r;
   pmpw_top_s n;
   logic mem_we;
   logic [1:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic [1:0] mem_raddr;
   logic [7:0] mem_rdata;
   logic [1:0] tgt;
   logic rch;
   logic boot_done;
   logic [1:0] chan_gate;
   // Unpacked so each generate branch owns its own element
   pmpw_chan_ctl_s ctl [2];

   // Status byte of one channel; unit-off follows the live gate state
   function automatic logic [7:0] status_byte(logic off, logic cml, logic flt);
      logic [7:0] s;
      s = BYTE_ZERO;
      s[ST_OFF_BIT] = off;
      s[ST_CML_BIT] = cml;
      s[ST_FAULT_BIT] = flt;
      return s;
   endfunction : status_byte

   function automatic logic cmd_known(logic [7:0] code);
      return (code == CMD_PAGE) || (code == CMD_OPERATION) || (code == CMD_ONOFF_CFG) ||
             (code == CMD_CLEAR_FAULTS) || (code == CMD_WRITE_LOCK) ||
             (code == CMD_STORE_ALL) || (code == CMD_RESTORE_ALL) || (code == CMD_STATUS);
   endfunction : cmd_known

   always_comb begin
      tgt = r.page_all ? 2'b11 : (r.page_idx ? 2'b10 : 2'b01);
      rch = r.page_all ? 1'b0 : r.page_idx;
   end

   always_comb begin
      n = r;
      n.rsp = '0;
      mem_we = 1'b0;
      mem_waddr = r.cnt;
      mem_wdata = BYTE_ZERO;
      mem_raddr = r.cnt;

      case (r.fsm)
         ST_LOAD: begin
            // Read data lag one cycle behind the address
            if (r.cnt == CNT_ONE) begin
               n.cfg[0] = mem_rdata & CFG_WR_MASK;
               if (!r.restore) begin
                  n.pol_active[0] = mem_rdata[CFG_POL_BIT];
               end
            end else if (r.cnt == NVM_LAST) begin
               n.cfg[1] = mem_rdata & CFG_WR_MASK;
               if (!r.restore) begin
                  n.pol_active[1] = mem_rdata[CFG_POL_BIT];
               end
            end else if (r.cnt != CNT_ZERO) begin
               n.wp = mem_rdata & WP_WR_MASK;
            end
            if (r.cnt == (NVM_LAST + CNT_ONE)) begin
               n.fsm = ST_IDLE;
               n.cnt = CNT_ZERO;
               n.restore = 1'b0;
            end else begin
               n.cnt = r.cnt + CNT_ONE;
            end
         end
         ST_SAVE: begin
            mem_we = 1'b1;
            if (r.cnt == NVM_LAST) begin
               mem_wdata = r.wp;
               n.fsm = ST_IDLE;
               n.cnt = CNT_ZERO;
            end else begin
               mem_wdata = r.cfg[r.cnt[0]];
               n.cnt = r.cnt + CNT_ONE;
            end
         end
         default: begin
            n.fsm = ST_IDLE;
         end
      endcase

      if (cmd_req.valid) begin
         n.rsp.valid = 1'b1;
         n.rsp.ack = 1'b1;
         if (r.fsm != ST_IDLE) begin
            // Busy with a store or load: commands are refused, not queued
            n.rsp.ack = 1'b0;
         end else if (!cmd_known(cmd_req.code)) begin
            n.rsp.ack = 1'b0;
            n.cml_st = r.cml_st | tgt;
         end else if (!cmd_req.write) begin
            // Reads are never gated by the write lock
            if (cmd_req.code == CMD_PAGE) begin
               n.rsp.rdata[PAGE_ALL_BIT] = r.page_all;
               n.rsp.rdata[PAGE_IDX_BIT] = r.page_idx;
            end else if (cmd_req.code == CMD_OPERATION) begin
               n.rsp.rdata = r.op[rch];
            end else if (cmd_req.code == CMD_ONOFF_CFG) begin
               n.rsp.rdata = r.cfg[rch];
            end else if (cmd_req.code == CMD_WRITE_LOCK) begin
               n.rsp.rdata = r.wp;
            end else if (cmd_req.code == CMD_STATUS) begin
               n.rsp.rdata = status_byte(~chan_gate[rch], r.cml_st[rch], r.fault_st[rch]);
            end else begin
               n.rsp.ack = 1'b0;
            end
         end else if (!wp_allows(r.wp, cmd_req.code)) begin
            n.rsp.ack = 1'b0;
            n.cml_st = r.cml_st | tgt;
         end else if (cmd_req.code == CMD_PAGE) begin
            if (cmd_req.wdata[PAGE_ALL_BIT] && !cmd_req.wdata[PAGE_IDX_BIT]) begin
               n.page_all = r.page_all;
            end else begin
               n.page_all = cmd_req.wdata[PAGE_ALL_BIT];
               n.page_idx = cmd_req.wdata[PAGE_IDX_BIT];
            end
         end else if (cmd_req.code == CMD_OPERATION) begin
            if (margin_known(cmd_req.wdata[OP_MRG_HI:OP_MRG_LO])) begin
               for (int c = 0; c < 2; c++) begin
                  if (tgt[c]) begin
                     n.op[c] = cmd_req.wdata & OP_WR_MASK;
                  end
               end
            end else begin
               n.rsp.ack = 1'b0;
               n.cml_st = r.cml_st | tgt;
            end
         end else if (cmd_req.code == CMD_ONOFF_CFG) begin
            for (int c = 0; c < 2; c++) begin
               if (tgt[c]) begin
                  n.cfg[c] = cmd_req.wdata & CFG_WR_MASK;
               end
            end
         end else if (cmd_req.code == CMD_CLEAR_FAULTS) begin
            // Data byte is not looked at
            n.fault_st = r.fault_st & ~tgt;
            n.cml_st = r.cml_st & ~tgt;
         end else if (cmd_req.code == CMD_WRITE_LOCK) begin
            if (wp_legal(cmd_req.wdata)) begin
               n.wp = cmd_req.wdata & WP_WR_MASK;
            end else begin
               n.rsp.ack = 1'b0;
               n.cml_st = r.cml_st | tgt;
            end
         end else if (cmd_req.code == CMD_STORE_ALL) begin
            n.fsm = ST_SAVE;
            n.cnt = CNT_ZERO;
         end else if (cmd_req.code == CMD_RESTORE_ALL) begin
            n.fsm = ST_LOAD;
            n.cnt = CNT_ZERO;
            n.restore = 1'b1;
         end
         // Status register writes fall through here and are dropped
      end

      // Sets come after clears so a live fault survives the clear
      n.fault_st = n.fault_st | fault_present;
      n.alert_n = ~|(n.fault_st | n.cml_st);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         r <= TOP_RESET;
      end else begin
         r <= n;
      end
   end

   assign boot_done = (r.fsm != ST_LOAD);

   pmpw_nvm u_nvm (
      .clk_sys(clk_sys),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   for (genvar g = 0; g < 2; g++) begin : g_chan
      always_comb begin
         ctl[g].on = r.op[g][OP_ON_BIT];
         ctl[g].pu = r.cfg[g][CFG_PU_BIT];
         ctl[g].cmd = r.cfg[g][CFG_CMD_BIT];
         ctl[g].cpr = r.cfg[g][CFG_CPR_BIT];
         ctl[g].pol = r.pol_active[g];
         ctl[g].margin = margin_decode(r.op[g][OP_MRG_HI:OP_MRG_LO]);
         ctl[g].act = !((r.op[g][OP_MRG_HI:OP_MRG_LO] == MRG_LOW_IGN) ||
                        (r.op[g][OP_MRG_HI:OP_MRG_LO] == MRG_HIGH_IGN));
      end

      pmpw_chan u_chan (
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .ctl(ctl[g]),
         .boot_done(boot_done),
         .pin(channel_control_pin[g]),
         .fault(fault_present[g]),
         .power_ok(power_ok),
         .gate_en(chan_gate[g]),
         .margin(margin_mode[g]),
         .act_on_fault(margin_act_on_fault[g])
      );
   end

   assign gate_enable = chan_gate;
   assign cmd_rsp = r.rsp;
   assign smbalert_n = r.alert_n;
endmodule : pmpw_top

// File: bench/pmpw_top_assertions.sv
// Port checker for the command register block
`timescale 1ns/1ps
module pmpw_chk import pmpw_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Command port
   input wire pmpw_pkg::pmpw_req_s cmd_req,
   input wire pmpw_pkg::pmpw_rsp_s cmd_rsp,
   // Channel side
   input wire logic [1:0] fault_present,
   input wire logic power_ok,
   input wire logic [1:0] gate_enable,
   input wire pmpw_pkg::pmpw_margin_e [1:0] margin_mode,
   input wire logic [1:0] margin_act_on_fault,
   input wire logic smbalert_n
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // Fault-free clear; only status of a channel outside the page can still hold the alert
   sequence s_clear;
      cmd_req.valid && cmd_req.write && cmd_req.code == CMD_CLEAR_FAULTS &&
      fault_present == 2'h0 ##1 cmd_rsp.ack && fault_present == 2'h0;
   endsequence
   sequence s_bad_lock;
      cmd_req.valid && cmd_req.write && cmd_req.code == CMD_WRITE_LOCK &&
      $countones(cmd_req.wdata[7:5]) > 1;
   endsequence
   a_rsp_follows: assert property (cmd_req.valid |=> cmd_rsp.valid)
      else $error("Command got no answer on the next cycle");
   a_rsp_cause: assert property (cmd_rsp.valid |-> $past(cmd_req.valid))
      else $error("Answer without a command");
   a_nack_quiet: assert property (cmd_rsp.valid && !cmd_rsp.ack |-> cmd_rsp.rdata == 8'h00)
      else $error("Refused command returned data");
   a_lock_invalid: assert property (s_bad_lock |=> cmd_rsp.valid && !cmd_rsp.ack ##1 !smbalert_n)
      else $error("Invalid lock value not refused with alert");
   a_clear_alert: assert property (s_clear |-> ##[0:1] smbalert_n)
      else $error("Clear did not release the alert");
   a_fault_alert: assert property ((|fault_present) ##1 (|fault_present) |-> ##[0:1] !smbalert_n)
      else $error("Live fault without alert");
   a_power_off: assert property (!power_ok |=> gate_enable == 2'h0)
      else $error("Gate enabled without power");
   a_margin_act: assert property (margin_mode[0] == MRG_OFF |-> margin_act_on_fault[0])
      else $error("Margin off must act on faults");
   a_reset_safe: assert property ($rose(rst_n) |-> gate_enable == 2'h0 && smbalert_n)
      else $error("Outputs not safe after reset");
endmodule : pmpw_chk

bind pmpw_top pmpw_chk pmpw_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_req(cmd_req),
   .cmd_rsp(cmd_rsp), .fault_present(fault_present), .power_ok(power_ok),
   .gate_enable(gate_enable), .margin_mode(margin_mode),
   .margin_act_on_fault(margin_act_on_fault), .smbalert_n(smbalert_n));

// File: bench/pmpw_host.sv
// Host model issuing single-byte commands on the command port
`timescale 1ns/1ps
module pmpw_host import pmpw_pkg::*; (
   // Clock
   input wire logic clk_sys,
   // Command port
   output pmpw_pkg::pmpw_req_s cmd_req,
   input wire pmpw_pkg::pmpw_rsp_s cmd_rsp
);
   initial cmd_req = '0;
   // Caller alone chooses a multi-bit lock value
   task automatic xfer(input logic w, input logic [7:0] code, input logic [7:0] wd,
      output logic [9:0] r);
      @(posedge clk_sys);
      cmd_req <= '{1'b1, w, code, wd};
      @(posedge clk_sys);
      // Released fields flip so stale values never look valid
      cmd_req <= '{1'b0, ~w, ~code, ~wd};
      @(posedge clk_sys);
      r = {cmd_rsp.valid, cmd_rsp.ack, cmd_rsp.rdata};
   endtask : xfer
endmodule : pmpw_host

// File: bench/pmpw_top_tb.sv
// Self-checking bench for the command register block
`timescale 1ns/1ps
module pmpw_top_tb;
   import pmpw_pkg::*;
   localparam logic [7:0] CODES [6] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h78, 8'h20};
   localparam logic [7:0] MRG [9] = '{8'h80, 8'h94, 8'h98, 8'hA4, 8'hA8, 8'h88, 8'h90, 8'hBC, 8'h14};
   localparam logic [7:0] PG [4] = '{8'h80, 8'h81, 8'h01, 8'h00};
   localparam logic [7:0] LK [4] = '{8'h20, 8'h40, 8'h80, 8'h60};
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   pmpw_req_s cmd_req;
   pmpw_rsp_s cmd_rsp;
   logic [1:0] pin = 2'h3;
   logic [1:0] flt = 2'h0;
   logic pwr = 1'b1;
   logic [1:0] gate;
   pmpw_margin_e [1:0] mm;
   logic [1:0] act;
   logic alert_n;
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [7:0] page, lock, nlock;
   logic [7:0] op [2];
   logic [7:0] cfg [2];
   logic [7:0] ncfg [2];
   logic [1:0] pol, cml, lat;
   logic [9:0] rr;

   always #2.5 clk_sys = ~clk_sys;
   pmpw_top pmpw_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_req(cmd_req),
      .cmd_rsp(cmd_rsp), .channel_control_pin(pin), .fault_present(flt), .power_ok(pwr),
      .gate_enable(gate), .margin_mode(mm), .margin_act_on_fault(act), .smbalert_n(alert_n));
   pmpw_host pmpw_host_inst (.clk_sys(clk_sys), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp));

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask : cmp

   // Returns act flag above the margin mode
   function automatic logic [2:0] mexp(input logic [7:0] o);
      logic a;
      a = o[5:2] != 4'h5 && o[5:2] != 4'h9;
      if (o[5:2] == 4'h5 || o[5:2] == 4'h6) return {a, 2'h1};
      if (o[5:2] == 4'h9 || o[5:2] == 4'hA) return {a, 2'h2};
      return {a, 2'h0};
   endfunction : mexp

   function automatic logic gexp(input int c);
      logic on;
      on = !cfg[c][4] | ((!cfg[c][3] | op[c][7]) & (!cfg[c][2] | (pin[c] == pol[c])));
      return pwr & on & !lat[c];
   endfunction : gexp

   task automatic chk_out();
      logic [2:0] m0, m1;
      @(posedge clk_sys);
      #1;
      m0 = mexp(op[0]);
      m1 = mexp(op[1]);
      cmp("gate", {14'h0, gexp(1), gexp(0)}, {14'h0, gate});
      cmp("margin", {10'h0, m1[2], m0[2], m1[1:0], m0[1:0]}, {10'h0, act, mm});
   endtask : chk_out

   task automatic cmd(input logic w, input logic [7:0] code, input logic [7:0] wd);
      logic [9:0] r;
      logic ack, blk;
      logic [7:0] rd;
      logic [1:0] tm;
      int c;
      tm = (page == 8'h81) ? 2'h3 : (page[0] ? 2'h2 : 2'h1);
      c = (page == 8'h01) ? 1 : 0;
      blk = lock[7] | (lock[6] & (code > 8'h01)) | (lock[5] & (code > 8'h02));
      ack = code inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h15, 8'h16, 8'h78};
      ack = ack & (!w | (code == CMD_WRITE_LOCK) | !blk);
      if (w && code == 8'h01 && wd[5:4] != 2'h0 && !(wd[5:2] inside {5, 6, 9, 10})) ack = 0;
      if (w && code == CMD_WRITE_LOCK && $countones(wd[7:5]) > 1) ack = 1'b0;
      rd = 8'h00;
      if (ack && !w) begin
         case (code)
            CMD_PAGE: rd = page;
            CMD_OPERATION: rd = op[c];
            CMD_ONOFF_CFG: rd = cfg[c];
            CMD_WRITE_LOCK: rd = lock;
            default: rd = {1'b0, !gexp(c), 4'h0, cml[c], 1'b0};
         endcase
      end
      pmpw_host_inst.xfer(w, code, wd, r);
      cmp("response", {7'h1, ack, rd}, {6'h0, r});
      if (!ack) begin
         cml = cml | tm;
      end else if (w) begin
         case (code)
            CMD_PAGE: if (!(wd[7] && !wd[0])) page = wd & PAGE_WR_MASK;
            CMD_OPERATION: for (int i = 0; i < 2; i++) if (tm[i]) op[i] = wd & OP_WR_MASK;
            CMD_ONOFF_CFG: for (int i = 0; i < 2; i++) if (tm[i]) cfg[i] = wd & CFG_WR_MASK;
            CMD_CLEAR_FAULTS: cml = cml & ~tm;
            CMD_WRITE_LOCK: lock = wd & WP_WR_MASK;
            CMD_STORE_ALL: begin
               ncfg = cfg;
               nlock = lock;
            end
            CMD_RESTORE_ALL: begin
               cfg = ncfg;
               lock = nlock;
            end
            default: ;
         endcase
      end
      // Store and restore keep the block busy a few cycles
      if (code == CMD_STORE_ALL || code == CMD_RESTORE_ALL) repeat (5) @(posedge clk_sys);
      chk_out();
   endtask : cmd

   task automatic reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      page = 8'h00;
      lock = nlock;
      cfg = ncfg;
      op = '{8'h00, 8'h00};
      pol = {ncfg[1][1], ncfg[0][1]};
      cml = 2'h0;
      lat = 2'h0;
      repeat (8) @(posedge clk_sys);
   endtask : reset

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      void'($urandom(65));
      nlock = 8'h00;
      ncfg = '{8'h16, 8'h16};
      reset();
      for (int i = 0; i < 5; i++) cmd(1'b0, CODES[i], 8'h00);
      cmd(1'b1, CMD_ONOFF_CFG, 8'hFF);
      cmd(1'b1, CMD_ONOFF_CFG, 8'h1E);
      foreach (MRG[i]) cmd(1'b1, CMD_OPERATION, MRG[i]);
      cmd(1'b1, CMD_PAGE, 8'h01);
      cmd(1'b1, CMD_OPERATION, 8'h84);
      foreach (PG[i]) begin
         cmd(1'b1, CMD_PAGE, PG[i]);
         cmd(1'b0, CMD_OPERATION, 8'h00);
      end
      foreach (LK[i]) begin
         cmd(1'b1, CMD_WRITE_LOCK, LK[i]);
         cmd(1'b1, CMD_ONOFF_CFG, 8'h10 | (LK[i] >> 3));
         cmd(1'b1, CMD_OPERATION, LK[i] ^ 8'h80);
         cmd(1'b1, CMD_PAGE, 8'h81);
         cmd(1'b1, CMD_STATUS, 8'h00);
         cmd(1'b0, CMD_ONOFF_CFG, 8'h00);
         cmd(1'b1, CMD_WRITE_LOCK, 8'hE0);
      end
      // Random traffic with moving pins
      for (int i = 0; i < 150; i++) begin
         @(posedge clk_sys);
         pin <= 2'($urandom);
         // Let the new pin settle before the status expectation is formed
         #1;
         cmd(1'($urandom), CODES[$urandom % 6], 8'($urandom));
      end
      @(posedge clk_sys);
      pwr <= 1'b0;
      chk_out();
      @(posedge clk_sys);
      pwr <= 1'b1;
      cmd(1'b1, CMD_WRITE_LOCK, 8'h00);
      cmd(1'b1, CMD_PAGE, 8'h81);
      cmd(1'b1, CMD_ONOFF_CFG, 8'h18);
      cmd(1'b1, CMD_OPERATION, 8'h80);
      @(posedge clk_sys);
      flt <= 2'h1;
      lat[0] = 1'b1;
      repeat (3) @(posedge clk_sys);
      flt <= 2'h0;
      chk_out();
      @(posedge clk_sys);
      flt <= 2'h1;
      cmd(1'b1, CMD_CLEAR_FAULTS, 8'h5A);
      cmp("alert", 16'h0, {15'h0, alert_n});
      @(posedge clk_sys);
      flt <= 2'h0;
      cmd(1'b1, CMD_CLEAR_FAULTS, 8'hA5);
      cmp("alert", 16'h1, {15'h0, alert_n});
      cmd(1'b1, CMD_OPERATION, 8'h00);
      lat = 2'h0;
      cmd(1'b1, CMD_OPERATION, 8'h80);
      cmd(1'b0, CMD_STATUS, 8'h00);
      cmd(1'b1, CMD_PAGE, 8'h00);
      cmd(1'b1, CMD_ONOFF_CFG, 8'h14);
      @(posedge clk_sys);
      pin <= 2'h1;
      cmd(1'b1, CMD_STORE_ALL, 8'h00);
      cmd(1'b1, CMD_ONOFF_CFG, 8'h16);
      cmd(1'b1, CMD_RESTORE_ALL, 8'h00);
      cmd(1'b0, CMD_ONOFF_CFG, 8'h00);
      reset();
      cmd(1'b0, CMD_ONOFF_CFG, 8'h00);
      // Back-to-back after a store: the second command lands while busy
      pmpw_host_inst.xfer(1'b1, CMD_STORE_ALL, 8'h00, rr);
      cmp("store", 16'h300, {6'h0, rr});
      pmpw_host_inst.xfer(1'b0, CMD_WRITE_LOCK, 8'h00, rr);
      cmp("busy", 16'h200, {6'h0, rr});
      repeat (5) @(posedge clk_sys);
      results();
   end
endmodule : pmpw_top_tb
